// File: switch_bank_model.sv
/*
  Model of the switches and band/polarization circuitry fed by the block.
  Resolves what each control line carries at the far side.
  Assumes output 3 has a pull-up and the other lines are always driven.
*/
`timescale 1ns/100ps
`default_nettype none

module switch_bank_model (
  input  wire logic [7:0] drive,
  input  wire logic       pos_oe,
  output logic      [7:0] level
);
  // Output 3 falls back to its pull-up while the block leaves it an input
  assign level = {drive[7:3], (pos_oe ? drive[2] : 1'b1), drive[1:0]};
endmodule

`default_nettype wire

// File: switch_output_mode_logic.sv
/*
  Switch output mode logic of a slave controller for LNBs and switchers.
  Holds the selection state, applies commands from the bus frame receiver,
  maps backwards compatible tone and voltage signalling, and drives the
  eight switch outputs, standby and the output 3 enable from flip-flops.
  Assumes commands arrive as one-cycle strobes synchronous to clk_sys,
  already address-checked by the frame receiver.
*/
`timescale 1ns/100ps
`default_nettype none

module switch_output_mode_logic (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       reset_pin_n,
  input  wire logic       low_supply_detector,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_data,
  input  wire logic       prog_valid,
  input  wire logic [7:0] prog_index,
  input  wire logic [7:0] prog_data,
  input  wire logic       tone_detect,
  input  wire logic       voltage_high,
  output logic            band_select_out,
  output logic            polarization_out,
  output logic            position_select_out,
  output logic            position_select_oe,
  output logic            switch_option_out,
  output logic            uncommitted_out_a,
  output logic            uncommitted_out_b,
  output logic            uncommitted_out_c,
  output logic            uncommitted_out_d,
  output logic            standby_out,
  output logic            compat_mode,
  output logic [7:0]      slave_address_out,
  output logic [7:0]      out_cfg_out
);

  typedef enum logic [2:0] {
    ST_RESET  = 3'h1,
    ST_COMPAT = 3'h2,
    ST_BUS    = 3'h4
  } ctl_state_t;

  ctl_state_t state;
  ctl_state_t next_state;
  logic [7:0] sel;
  logic [7:0] next_sel;
  logic [7:0] outs;
  logic       standby_req;
  logic       next_standby_req;
  logic       pos_oe;

  wire [7:0] slave_address;
  wire [7:0] out_cfg;
  wire       standby_used;
  wire       store_locked;
  wire [7:0] pattern;

  // Every reset source collapses to one synchronous reset of the control state
  wire core_reset = reset | low_supply_detector | ~reset_pin_n;

  switch_param_store u_store (
    .clk_sys        (clk_sys),
    .power_on_reset (reset),
    .prog_valid     (prog_valid),
    .prog_index     (prog_index),
    .prog_data      (prog_data),
    .slave_address  (slave_address),
    .lo_freq        (),
    .out_cfg        (out_cfg),
    .standby_used   (standby_used),
    .locked         (store_locked)
  );

  // Command decode
  wire cmd_reset   = cmd_valid && cmd_code == switch_output_pkg::CMD_RESET;
  wire cmd_standby = cmd_valid && cmd_code == switch_output_pkg::CMD_STANDBY;
  wire cmd_power   = cmd_valid && cmd_code == switch_output_pkg::CMD_POWER_ON;
  wire cmd_single  = cmd_valid && cmd_code[7:4] == switch_output_pkg::CMD_SEL_HI;
  wire cmd_n0      = cmd_valid && cmd_code == switch_output_pkg::CMD_WRITE_N0;
  wire cmd_n1      = cmd_valid && cmd_code == switch_output_pkg::CMD_WRITE_N1;

  // Single select: low bits pick the line, bit 2 the value, bit 3 the group
  wire [2:0] single_idx = {cmd_code[switch_output_pkg::SEL_GRP_BIT], cmd_code[1:0]};
  wire       single_val = cmd_code[switch_output_pkg::SEL_VAL_BIT];

  // Any frame other than the reset command leaves compatible mode
  always_comb begin
    next_state = state;
    case (state)
      ST_RESET:  next_state = ST_COMPAT;
      ST_COMPAT: next_state = (cmd_valid && !cmd_reset) ? ST_BUS : ST_COMPAT;
      ST_BUS:    next_state = cmd_reset ? ST_COMPAT : ST_BUS;
      default:   next_state = ST_RESET;
    endcase
  end

  // Selection state: group writes and single selects from bus commands
  always_comb begin
    next_sel = sel;
    if (cmd_n0) begin
      next_sel[3:0] = cmd_data[3:0];
    end else if (cmd_n1) begin
      next_sel[7:4] = cmd_data[3:0];
    end else if (cmd_single) begin
      next_sel[single_idx] = single_val;
    end
  end

  assign next_standby_req = cmd_standby ? 1'b1 : cmd_power ? 1'b0 : standby_req;

  // Compatible mode: tone goes to band or position, voltage to polarization
  wire       tone_to_pos = out_cfg[switch_output_pkg::CFG_TONE_BIT];
  wire [7:0] compat_sel  = {sel[7:4], sel[switch_output_pkg::SEL_OPTION],
                            tone_to_pos ? tone_detect : sel[switch_output_pkg::SEL_POS],
                            voltage_high,
                            tone_to_pos ? sel[switch_output_pkg::SEL_BAND] : tone_detect};
  wire [7:0] eff_sel     = (state == ST_BUS) ? sel : compat_sel;

  switch_pattern_decoder u_decode (
    .sel     (eff_sel),
    .cfg     (out_cfg),
    .pattern (pattern)
  );

  // Control state registers
  always_ff @(posedge clk_sys) begin
    if (core_reset) begin
      state       <= ST_RESET;
      sel         <= switch_output_pkg::SEL_RESET;
      standby_req <= 1'b0;
    end else begin
      state       <= next_state;
      sel         <= next_sel;
      standby_req <= next_standby_req;
    end
  end

  // Outputs registered so decode changes never glitch the switch lines
  always_ff @(posedge clk_sys) begin
    if (core_reset) begin
      outs <= switch_output_pkg::OUT_RESET;
    end else begin
      outs <= pattern;
    end
  end

  // Output 3 falls back to a pulled-up input on every reset
  always_ff @(posedge clk_sys) begin
    if (core_reset) begin
      pos_oe <= 1'b0;
    end else begin
      pos_oe <= state != ST_RESET;
    end
  end

  // Standby and status mirrors
  always_ff @(posedge clk_sys) begin
    if (core_reset) begin
      standby_out       <= 1'b0;
      compat_mode       <= 1'b0;
      slave_address_out <= switch_output_pkg::DEF_ADDRESS;
      out_cfg_out       <= switch_output_pkg::DEF_OUT_CFG;
    end else begin
      standby_out       <= standby_used && next_standby_req;
      compat_mode       <= next_state != ST_BUS;
      slave_address_out <= slave_address;
      out_cfg_out       <= out_cfg;
    end
  end

  assign band_select_out     = outs[0];
  assign polarization_out    = outs[1];
  assign position_select_out = outs[2];
  assign position_select_oe  = pos_oe;
  assign switch_option_out   = outs[3];
  assign uncommitted_out_a   = outs[4];
  assign uncommitted_out_b   = outs[5];
  assign uncommitted_out_c   = outs[6];
  assign uncommitted_out_d   = outs[7];

  // Mode views of the configuration for the checks below
  wire cfg_decoded = out_cfg[4:1] != 4'h0;
  wire cfg_two     = out_cfg[switch_output_pkg::CFG_TWO_BIT];
  wire cfg_comp    = out_cfg[switch_output_pkg::CFG_COMP_BIT];
  wire cfg_single  = !cfg_decoded && !cfg_comp;

  single_direct_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single && state == ST_BUS && !cmd_valid ##1 !core_reset |-> outs == $past(sel))
    else $error("single polarity output does not follow selection");

  band_map_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single && state == ST_BUS && cmd_valid && cmd_code == 8'h24 ##2 cfg_single
      |-> band_select_out)
    else $error("band select output not high after high band select");

  onehot_eight_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_decoded && !cfg_two |=> $onehot(outs) || $past(core_reset))
    else $error("decoded output not one-hot");

  onehot_four_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_decoded && cfg_two |=> (outs[7:4] == 4'h0 && $onehot(outs[3:0])) || $past(core_reset))
    else $error("two-line decoded output not 1 of 4");

  complement_pair_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    !cfg_decoded && cfg_comp |=> outs[7:4] == ~outs[3:0] || $past(core_reset))
    else $error("uncommitted outputs not inverse of committed");

  tone_route_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single && state == ST_COMPAT && tone_to_pos |=>
      position_select_out == $past(tone_detect) || $past(core_reset))
    else $error("tone not routed to position output");

  pos_release_a: assert property (@(posedge clk_sys)
    core_reset |=> !position_select_oe)
    else $error("output 3 driven right after reset");

  low_supply_hold_a: assert property (@(posedge clk_sys)
    low_supply_detector [*2] |-> outs == 8'h00 && !standby_out && state == ST_RESET)
    else $error("outputs active while supply is low");

  group_load_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_n1 |=> sel[7:4] == $past(cmd_data[3:0]) && sel[3:0] == $past(sel[3:0]))
    else $error("uncommitted group write not loaded whole");

  standby_gate_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_standby && !standby_used |=> !standby_out)
    else $error("standby driven while not in use");

  group_low_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_n0 |=> sel[3:0] == $past(cmd_data[3:0]) && sel[7:4] == $past(sel[7:4]))
    else $error("committed group write not loaded whole");

  single_select_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_single |=> sel[$past(single_idx)] == $past(single_val))
    else $error("single select did not set its line");

  registered_out_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    $stable(eff_sel) && $stable(out_cfg) |=> $stable(outs) || $past(core_reset, 2))
    else $error("switch outputs moved with no input change");

  standby_set_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_standby && standby_used |=> standby_out)
    else $error("standby not driven while in use");

  standby_clear_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_power |=> !standby_out)
    else $error("standby still driven after power on command");

  compat_entry_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cmd_reset |=> compat_mode && state == ST_COMPAT)
    else $error("reset command did not return to compatible mode");

  bus_entry_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    state != ST_RESET && cmd_valid && !cmd_reset |=> !compat_mode && state == ST_BUS)
    else $error("bus command did not leave compatible mode");

  lock_hold_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    store_locked && prog_valid |=> slave_address == $past(slave_address)
      && out_cfg == $past(out_cfg))
    else $error("locked parameter store accepted a write");

  pos_drive_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    state != ST_RESET |=> position_select_oe)
    else $error("output 3 not driven after reset");

  single_upper_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single |=> outs[7:4] == $past(sel[7:4]))
    else $error("uncommitted outputs do not follow their selections");

  comp_lower_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    !cfg_decoded && cfg_comp |=> outs[3:0] == $past(eff_sel[3:0]))
    else $error("committed outputs wrong in complementary mode");

  reset_clear_a: assert property (@(posedge clk_sys)
    !reset_pin_n |=> outs == 8'h00 && !standby_out && !compat_mode && state == ST_RESET)
    else $error("outputs active while reset pin is low");

  compat_voltage_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single && state == ST_COMPAT |=> polarization_out == $past(voltage_high))
    else $error("voltage not routed to polarization output");

  compat_band_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    cfg_single && state == ST_COMPAT && !tone_to_pos
      |=> band_select_out == $past(tone_detect))
    else $error("tone not routed to band output");

  decode_first_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    out_cfg[4:1] == 4'h1 && !cfg_two |=> outs == (8'h01 << $past(eff_sel[2:0])))
    else $error("decoded pattern does not match selections");

  decode_pair_a: assert property (@(posedge clk_sys) disable iff (core_reset)
    out_cfg[4:1] == 4'h3 && cfg_two |=> outs == (8'h01 << $past(eff_sel[3:2])))
    else $error("two-line pattern does not match selections");

  cover_decoded_c: cover property (@(posedge clk_sys) cfg_decoded && !cfg_two && outs[7]);
  cover_comp_c:    cover property (@(posedge clk_sys) cfg_comp && state == ST_BUS && outs[4]);
  cover_return_c:  cover property (@(posedge clk_sys) state == ST_BUS ##1 state == ST_COMPAT);
  cover_standby_c: cover property (@(posedge clk_sys) standby_out);
  cover_two_c:     cover property (@(posedge clk_sys) cfg_decoded && cfg_two && outs[3]);

endmodule

`default_nettype wire

// File: switch_output_mode_logic_tb.sv
/*
  Self-checking bench for the switch output mode logic, with a small
  behavioural model of selections, modes and compatible signalling.
  Assumes the default of the standby use parameter is 1.
*/
`timescale 1ns/100ps
`default_nettype none

module switch_output_mode_logic_tb;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic        low_supply_detector = 1'b0;
  logic        cmd_valid = 1'b0;
  logic [7:0]  cmd_code = 8'h00;
  logic [7:0]  cmd_data = 8'h00;
  logic        prog_valid = 1'b0;
  logic [7:0]  prog_index = 8'h00;
  logic [7:0]  prog_data = 8'h00;
  logic        tone_detect = 1'b0;
  logic        voltage_high = 1'b0;
  wire  [7:0]  outs;
  logic [7:0]  level;
  logic        oe;
  logic        standby_out;
  logic        compat_mode;
  logic [7:0]  slave_address_out;
  logic [7:0]  out_cfg_out;
  logic [7:0]  m_sel = 8'h00;
  logic        m_compat = 1'b1;
  logic [7:0]  seen;
  logic [31:0] seed = 32'h788A;
  int          n_errors = 0;
  int          tests_run = 0;

  // Clock at 100 MHz
  always #5 clk_sys = ~clk_sys;

  switch_output_mode_logic u_switch_output_mode_logic (
    .clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n),
    .low_supply_detector(low_supply_detector), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .prog_valid(prog_valid),
    .prog_index(prog_index), .prog_data(prog_data), .tone_detect(tone_detect),
    .voltage_high(voltage_high), .band_select_out(outs[0]),
    .polarization_out(outs[1]), .position_select_out(outs[2]),
    .position_select_oe(oe), .switch_option_out(outs[3]),
    .uncommitted_out_a(outs[4]), .uncommitted_out_b(outs[5]),
    .uncommitted_out_c(outs[6]), .uncommitted_out_d(outs[7]),
    .standby_out(standby_out), .compat_mode(compat_mode),
    .slave_address_out(slave_address_out), .out_cfg_out(out_cfg_out)
  );

  switch_bank_model u_switch_bank_model (.drive(outs), .pos_oe(oe), .level(level));

  // Next value of the stimulus register
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected pattern for single and complementary modes
  function automatic logic [7:0] model(input logic [7:0] s, input logic [7:0] cfg);
    logic [7:0] p;
    p = s;
    if (m_compat) begin
      p[1] = voltage_high;
      if (cfg[0]) p[2] = tone_detect;
      else p[0] = tone_detect;
    end
    if (cfg[5]) p[7:4] = ~p[3:0];
    return p;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command strobe; the model follows the selection update
  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    if (c == 8'h38) m_sel[3:0] = d[3:0];
    if (c == 8'h39) m_sel[7:4] = d[3:0];
    if (c[7:4] == 4'h2) m_sel[{c[3], c[1:0]}] = c[2];
    m_compat = (c == 8'h00);
    repeat (3) @(negedge clk_sys);
  endtask

  // One parameter write; outputs follow after two edges
  task automatic prog(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_sys);
    prog_valid = 1'b1;
    prog_index = i;
    prog_data = d;
    @(negedge clk_sys);
    prog_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  // Decoded pattern must be one-hot and new for every selection value
  task automatic onehot;
    tests_run++;
    if ($countones(outs) != 1 || (seen & outs) != 8'h00) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, outs, ~seen);
    end
    seen = seen | outs;
  endtask

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles of the sequence
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    chk(outs, 8'h00);
    chk({6'h00, oe, standby_out}, 8'h00);
    chk({7'h00, level[2]}, 8'h01);
    chk(slave_address_out, 8'h14);
    chk(out_cfg_out, 8'h0A);
    reset = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, oe}, 8'h01);
    $display("reset test done");
    prog(8'h02, 8'h00);
    chk(out_cfg_out, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      cmd(8'h38, seed[7:0]);
      cmd(8'h39, seed[15:8]);
      chk(outs, model(m_sel, 8'h00));
    end
    for (int c = 8'h20; c < 8'h30; c++) begin
      cmd(c[7:0], 8'h00);
      chk(outs, model(m_sel, 8'h00));
    end
    $display("single test done");
    prog(8'h02, 8'h20);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      cmd(8'h38, seed[7:0]);
      chk(outs, model(m_sel, 8'h20));
    end
    $display("complementary test done");
    prog(8'h02, 8'h02);
    seen = 8'h00;
    for (int v = 0; v < 8; v++) begin
      cmd(8'h38, v[7:0]);
      onehot();
    end
    prog(8'h02, 8'h46);
    seen = 8'h00;
    for (int v = 0; v < 4; v++) begin
      cmd(8'h38, {v[5:0], 2'b00});
      onehot();
    end
    $display("decoded test done");
    for (int k = 0; k < 2; k++) begin
      prog(8'h02, k[7:0]);
      cmd(8'h38, 8'h0A);
      cmd(8'h00, 8'h00);
      chk({7'h00, compat_mode}, 8'h01);
      for (int t = 0; t < 4; t++) begin
        @(negedge clk_sys);
        tone_detect = t[0];
        voltage_high = t[1];
        repeat (3) @(negedge clk_sys);
        chk(outs, model(m_sel, k[7:0]));
      end
    end
    $display("compatible test done");
    cmd(8'h02, 8'h00);
    chk({7'h00, standby_out}, 8'h01);
    cmd(8'h03, 8'h00);
    chk({7'h00, standby_out}, 8'h00);
    prog(8'h05, 8'h00);
    cmd(8'h02, 8'h00);
    chk({7'h00, standby_out}, 8'h00);
    $display("standby test done");
    prog(8'h00, 8'h11);
    chk(slave_address_out, 8'h11);
    prog(8'hFF, 8'hFF);
    prog(8'h00, 8'h15);
    chk(slave_address_out, 8'h11);
    $display("parameter test done");
    for (int r = 0; r < 2; r++) begin
      @(negedge clk_sys);
      low_supply_detector = (r == 0);
      reset_pin_n = (r != 0) ? 1'b0 : 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(outs, 8'h00);
      chk({6'h00, oe, standby_out}, 8'h00);
      chk({7'h00, level[2]}, 8'h01);
      low_supply_detector = 1'b0;
      reset_pin_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk({7'h00, oe}, 8'h01);
      chk(slave_address_out, 8'h11);
    end
    $display("reset source test done");
    end_of_test();
  end
endmodule

`default_nettype wire

// File: switch_output_pkg.sv
/*
  Constants for the switch output mode logic: configuration byte layout,
  stored parameter indices and defaults, command codes and reset values.
  Assumes nothing of its surroundings; used by every design file.
*/
package switch_output_pkg;

  // Output configuration byte fields
  localparam int CFG_TONE_BIT   = 0;
  localparam int CFG_DEC_LSB    = 1;
  localparam int CFG_DEC_W      = 4;
  localparam int CFG_COMP_BIT   = 5;
  localparam int CFG_TWO_BIT    = 6;

  // Selection vector positions, index 0 is output 1
  localparam int SEL_BAND       = 0;
  localparam int SEL_POL        = 1;
  localparam int SEL_POS        = 2;
  localparam int SEL_OPTION     = 3;

  // Stored parameter indices
  localparam logic [7:0] IDX_ADDRESS = 8'h00;
  localparam logic [7:0] IDX_LO_FREQ = 8'h01;
  localparam logic [7:0] IDX_OUT_CFG = 8'h02;
  localparam logic [7:0] IDX_STANDBY = 8'h05;
  localparam logic [7:0] LOCK_CODE   = 8'hFF;

  // Shipping defaults of the stored parameters
  localparam logic [7:0] DEF_ADDRESS = 8'h14;
  localparam logic [7:0] DEF_LO_FREQ = 8'h00;
  localparam logic [7:0] DEF_OUT_CFG = 8'h0A;
  localparam logic       DEF_STANDBY = 1'h1;

  // Command codes
  localparam logic [7:0] CMD_RESET    = 8'h00;
  localparam logic [7:0] CMD_STANDBY  = 8'h02;
  localparam logic [7:0] CMD_POWER_ON = 8'h03;
  localparam logic [3:0] CMD_SEL_HI   = 4'h2;
  localparam logic [7:0] CMD_WRITE_N0 = 8'h38;
  localparam logic [7:0] CMD_WRITE_N1 = 8'h39;
  localparam int         SEL_VAL_BIT  = 2;
  localparam int         SEL_GRP_BIT  = 3;

  // Reset values of the selection state and switch outputs
  localparam logic [7:0] SEL_RESET    = 8'h00;
  localparam logic [7:0] OUT_RESET    = 8'h00;

endpackage

// File: switch_param_store.sv
/*
  Programmed parameter store: slave address, local oscillator entries,
  output configuration byte and standby use, with a write lock.
  Assumes the programming strobe is one cycle wide and synchronous to clk_sys;
  contents survive every reset except the power-on reset input.
*/
`timescale 1ns/100ps
`default_nettype none

module switch_param_store (
  input  wire logic       clk_sys,
  input  wire logic       power_on_reset,
  input  wire logic       prog_valid,
  input  wire logic [7:0] prog_index,
  input  wire logic [7:0] prog_data,
  output logic      [7:0] slave_address,
  output logic      [7:0] lo_freq,
  output logic      [7:0] out_cfg,
  output logic            standby_used,
  output logic            locked
);

  // Lock code in both index and data freezes the store until the next power-on reset
  wire lock_hit  = prog_valid && prog_index == switch_output_pkg::LOCK_CODE
                   && prog_data == switch_output_pkg::LOCK_CODE;
  wire write_ok  = prog_valid && !locked;
  wire wr_addr   = write_ok && prog_index == switch_output_pkg::IDX_ADDRESS;
  wire wr_lo     = write_ok && prog_index == switch_output_pkg::IDX_LO_FREQ;
  wire wr_cfg    = write_ok && prog_index == switch_output_pkg::IDX_OUT_CFG;
  wire wr_sby    = write_ok && prog_index == switch_output_pkg::IDX_STANDBY;

  // Only programmed values steer the block, no pin is sampled for them
  always_ff @(posedge clk_sys) begin
    if (power_on_reset) begin
      slave_address <= switch_output_pkg::DEF_ADDRESS;
      lo_freq       <= switch_output_pkg::DEF_LO_FREQ;
      out_cfg       <= switch_output_pkg::DEF_OUT_CFG;
      standby_used  <= switch_output_pkg::DEF_STANDBY;
      locked        <= 1'b0;
    end else begin
      if (wr_addr) slave_address <= prog_data;
      if (wr_lo) lo_freq <= prog_data;
      if (wr_cfg) out_cfg <= {1'b0, prog_data[6:0]};
      if (wr_sby) standby_used <= prog_data[0];
      if (lock_hit) locked <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: switch_pattern_decoder.sv
/*
  Combinational pattern decoder: turns the eight selection bits and the
  output configuration byte into the next switch output pattern.
  Assumes its result is registered by the caller.
*/
`timescale 1ns/100ps
`default_nettype none

module switch_pattern_decoder (
  input  wire logic [7:0] sel,
  input  wire logic [7:0] cfg,
  output logic      [7:0] pattern
);

  // One-hot of a small binary value into an eight bit field
  function automatic logic [7:0] onehot8(input logic [2:0] v);
    onehot8 = 8'h01 << v;
  endfunction

  wire [3:0] dec_num  = cfg[switch_output_pkg::CFG_DEC_LSB +: switch_output_pkg::CFG_DEC_W];
  wire       two_line = cfg[switch_output_pkg::CFG_TWO_BIT];
  wire       comp     = cfg[switch_output_pkg::CFG_COMP_BIT];
  wire       decoded  = dec_num != 4'h0;
  // Mode number n starts the group at selection n; clamp so the group stays inside
  wire [3:0] base_raw = (dec_num > 4'h8) ? 4'h7 : dec_num - 4'h1;
  wire [3:0] lim      = two_line ? 4'h6 : 4'h5;
  wire [2:0] base     = (base_raw > lim) ? lim[2:0] : base_raw[2:0];
  wire [7:0] shifted  = sel >> base;
  wire [7:0] dec3     = onehot8(shifted[2:0]);
  wire [7:0] dec2     = onehot8({1'b0, shifted[1:0]});
  wire [7:0] complem  = {~sel[3:0], sel[3:0]};

  // Decoded wins over complementary when both are set; single otherwise
  assign pattern = decoded ? (two_line ? dec2 : dec3)
                 : comp ? complem
                 : sel;

endmodule

`default_nettype wire
